// >>> rtl/sed_regs.vh
// Constants and register map of the system error dispatcher
// Summary of operation
// (RL1) Timed-interrupt collision suspends program, dispatches collision handler, code in accumulator.
// (RL2) Without collision handler, collisions are ignored and the program continues.
// (RL3) A collision code already pending drops further events with that code.
// (RL4) Collision codes: 1 delay level, 2 to 5 time levels one to four.
// (RL5) I/O error suspends program, dispatches I/O error handler, code in accumulator.
// (RL6) Without I/O error handler, any I/O error enters stop mode.
// (RL7) I/O error during restart refuses start even with handler installed.
// (RL8) An I/O error code already pending is not stored again.
// (RL9) I/O codes: 1 powerfail, 2 bus hold, 3 ready fault, 4 link termination.
// (RL10) Powerfail during image transfer records ack timeout too, serviced after I/O errors.
// (RL11) Persisting I/O error re-invokes its handler each time the handler completes.
// (RL12) Scan-time monitor keeps running while a persistent I/O error is serviced.
// (RL13) Timeout and substitution errors call their handler, or stop without one.
// (RL14) Unloaded block call stores call code; indirect forms store second word only.
// (RL15) Without unloaded-block handler, execution continues after the missing call.
// (RL16) Direct access without ack in 160 us stores address, calls direct timeout handler.
// (RL17) Without direct timeout handler, stop and log ack timeout diagnostic.
// (RL18) Image update timeout stores address, calls its handler, or stops with diagnostic.
// (RL19) Substitution error runs substitution handler instead, or stops with diagnostic.
// (RL20) Substitution error on altered parameters or data word index beyond block length.
// (RL21) Several pending system errors are held and serviced one after another.
// (RL22) Handlers are masked only by selective level mask, not global disable.
// (RL23) One pending bit per code, cleared when its handler invocation begins.
`ifndef SED_REGS_VH
`define SED_REGS_VH
// Register indices; byte address is four times the index
`define SED_IDX_CALL_CODE 20'h0_E10CC
`define SED_IDX_FAULT_ADDR 20'h0_E10CE
`define SED_IDX_HANDLERS 20'h0_E1100
`define SED_IDX_LEVEL_MASK 20'h0_E1101
`define SED_IDX_STATUS 20'h0_E1102
// Handler identifiers, also bit positions in the handler and mask registers
`define SED_H_COLLISION 3'h0
`define SED_H_IO_ERROR 3'h1
`define SED_H_UNLOADED 3'h2
`define SED_H_DIRECT_TO 3'h3
`define SED_H_IMAGE_TO 3'h4
`define SED_H_SUBST 3'h5
`define SED_H_NONE 3'h7
// Diagnostic stack codes
`define SED_DIAG_NONE 4'h0
`define SED_DIAG_ACK_TO 4'h1
`define SED_DIAG_SUBST 4'h2
`define SED_DIAG_IO_ERROR 4'h3
`define SED_DIAG_RESTART_IO 4'h4
// Acknowledge deadline
`define SED_ACK_TIMEOUT_US 160
`define SED_CLK_PERIOD_NS 10
// Reset values
`define SED_HANDLERS_RST 6'h00
`define SED_MASK_RST 6'h00
`endif

// >>> rtl/sed_dispatcher.v
// System error dispatcher with AHB-Lite register slave
`timescale 1ns/1ps
`include "sed_regs.vh"
module sed_dispatcher #(
	parameter ACK_CYCLES = (`SED_ACK_TIMEOUT_US * 1000) / `SED_CLK_PERIOD_NS
) (
	// Clock and reset
	input wire clock,
	input wire rst_n,
	// AHB-Lite slave
	input wire hsel,
	input wire [31:0] haddr,
	input wire [1:0] htrans,
	input wire hwrite,
	input wire [2:0] hsize,
	input wire [31:0] hwdata,
	input wire hready,
	output reg [31:0] hrdata,
	output wire hreadyout,
	output wire hresp,
	// Timed-level requests from the scheduler, index 0 delay level, 1..4 time levels one..four
	input wire [4:0] levelRequest,
	input wire [4:0] levelBusy,
	// Backplane I/O error levels from pins, index 0 powerfail .. 3 link termination
	input wire [3:0] ioErrorPin,
	input wire moduleAckPin,
	// Bus controller access state
	input wire directAccess,
	input wire imageTransfer,
	input wire [31:0] accessAddress,
	// Execution unit events
	input wire restartPhase,
	input wire globalIntDisable,
	input wire handlerDone,
	input wire blockCallUnloaded,
	input wire callIndirect,
	input wire [15:0] callWord1,
	input wire [15:0] callWord2,
	input wire paramAltered,
	input wire dataWordOp,
	input wire [15:0] dataWordIndex,
	input wire [15:0] dataBlockLength,
	// Dispatch outputs
	output reg dispatch,
	output reg [2:0] handlerId,
	output reg [15:0] firstAccumulator,
	output reg handlerActive,
	output reg resumeNext,
	output reg stopMode,
	output reg refuseStart,
	output reg [3:0] diagCode,
	output wire scanMonitorRun
);
	localparam ST_IDLE = 1'b0;
	localparam ST_BUSY = 1'b1;
	localparam integer ACK_LAST_I = ACK_CYCLES - 1;
	localparam [15:0] ACK_LAST = ACK_LAST_I[15:0];

	// Address phase capture
	reg wrPend_q;
	reg [19:0] addrIdx_q;
	// Software registers
	reg [5:0] handlers_q, levelMask_q;
	reg [15:0] callCode_q;
	reg [31:0] faultAddr_q;
	// Synchronisers
	reg [3:0] ioMeta_q, ioSync_q, ioPrev_q;
	reg ackMeta_q, ackSync_q;
	// Pending state
	reg [4:0] collPend_q;
	reg [3:0] ioPend_q;
	reg dirToPend_q, imgToPend_q, unldPend_q, substPend_q;
	reg state_q;
	reg [15:0] ackCnt_q;
	reg ackFired_q;
	reg [2:0] curHandler_q;
	reg [3:0] ioServed_q;

	function [2:0] firstSet4;
		input [3:0] v;
		begin
			firstSet4 = v[0] ? 3'd0 : v[1] ? 3'd1 : v[2] ? 3'd2 : v[3] ? 3'd3 : 3'd4;
		end
	endfunction

	function isIdx;
		input [31:0] a;
		input [19:0] idx;
		begin
			isIdx = (a[31:2] == {10'h000, idx}) && (a[1:0] == 2'b00);
		end
	endfunction

	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	// Scan monitor keeps running during error servicing; only stop mode pauses it
	assign scanMonitorRun = !stopMode; // RL12

	wire addrPhase = hsel && htrans[1] && hready;

	// Event detection
	wire [3:0] ioRise = ioSync_q & ~ioPrev_q;
	wire [4:0] collEvent = levelRequest & levelBusy; // RL4
	wire ackWaiting = (directAccess || imageTransfer) && !ackSync_q;
	wire ackTimeout = ackWaiting && !ackFired_q && (ackCnt_q == ACK_LAST); // RL16
	wire pfDuringImage = ioRise[0] && imageTransfer; // RL10
	wire substEvent = paramAltered || (dataWordOp && (dataWordIndex > dataBlockLength)); // RL20
	wire ioHandled = (curHandler_q == `SED_H_IO_ERROR) && state_q == ST_BUSY;
	// Persisting errors rearm on handler completion
	wire [3:0] ioRearm = (ioHandled && handlerDone) ? (ioServed_q & ioSync_q) : 4'h0; // RL11

	// Selective mask only; global disable deliberately unused
	wire [5:0] enabled = ~levelMask_q; // RL22
	wire ioReady = |ioPend_q && enabled[`SED_H_IO_ERROR];
	wire collReady = |collPend_q && enabled[`SED_H_COLLISION];
	wire [2:0] ioSel = firstSet4(ioPend_q);
	// Delay level first, then time level one upwards
	wire [2:0] collSel = collPend_q[0] ? 3'd0 : firstSet4(collPend_q[4:1]) + 3'd1;

	reg [2:0] pick;
	reg [15:0] pickCode;
	always @* begin
		pick = `SED_H_NONE;
		pickCode = 16'h0000;
		// Fixed priority, one at a time
		if (ioReady) begin // RL21
			pick = `SED_H_IO_ERROR;
			pickCode = {13'h0000, ioSel} + 16'h0001; // RL9
		end else if (collReady) begin
			pick = `SED_H_COLLISION;
			pickCode = {13'h0000, collSel} + 16'h0001; // RL4
		end else if (imgToPend_q && |ioPend_q == 1'b0 && enabled[`SED_H_IMAGE_TO]) begin // RL10
			pick = `SED_H_IMAGE_TO;
		end else if (dirToPend_q && enabled[`SED_H_DIRECT_TO]) begin
			pick = `SED_H_DIRECT_TO;
		end else if (substPend_q && enabled[`SED_H_SUBST]) begin
			pick = `SED_H_SUBST;
		end else if (unldPend_q && enabled[`SED_H_UNLOADED]) begin
			pick = `SED_H_UNLOADED;
		end
	end

	wire canPick = (state_q == ST_IDLE) && (pick != `SED_H_NONE) && !stopMode;
	wire present = handlers_q[pick];
	wire take = canPick && present;
	wire [3:0] ioClr = (canPick && pick == `SED_H_IO_ERROR) ? (4'h1 << ioSel) : 4'h0;
	wire [4:0] collClr = (canPick && pick == `SED_H_COLLISION) ? (5'h01 << collSel) : 5'h00;

	// Synchronisers for backplane pins
	always @(posedge clock) begin
		if (!rst_n) begin
			ioMeta_q <= 4'h0;
			ioSync_q <= 4'h0;
			ioPrev_q <= 4'h0;
			ackMeta_q <= 1'b0;
			ackSync_q <= 1'b0;
		end else begin
			ioMeta_q <= ioErrorPin;
			ioSync_q <= ioMeta_q;
			ioPrev_q <= ioSync_q;
			ackMeta_q <= moduleAckPin;
			ackSync_q <= ackMeta_q;
		end
	end

	// Acknowledge watchdog shared by direct and image accesses
	// Holds once fired, so one stuck access raises one timeout only
	always @(posedge clock) begin
		if (!rst_n) begin
			ackCnt_q <= 16'h0000;
			ackFired_q <= 1'b0;
		end else if (!ackWaiting) begin
			ackCnt_q <= 16'h0000;
			ackFired_q <= 1'b0;
		end else if (ackTimeout) begin
			ackFired_q <= 1'b1;
		end else if (!ackFired_q) begin
			ackCnt_q <= ackCnt_q + 16'h0001;
		end
	end

	// Pending bits: new events win over the dispatch clear
	always @(posedge clock) begin
		if (!rst_n) begin
			collPend_q <= 5'h00;
			ioPend_q <= 4'h0;
			dirToPend_q <= 1'b0;
			imgToPend_q <= 1'b0;
			unldPend_q <= 1'b0;
			substPend_q <= 1'b0;
		end else begin
			// Repeat events merge into the existing bit
			collPend_q <= (collPend_q & ~collClr) | collEvent; // RL3 RL23
			ioPend_q <= (ioPend_q & ~ioClr) | ioRise | ioRearm; // RL8 RL23
			if (ackTimeout && directAccess && !imageTransfer) begin
				dirToPend_q <= 1'b1; // RL16
			end else if (canPick && pick == `SED_H_DIRECT_TO) begin
				dirToPend_q <= 1'b0;
			end
			if ((ackTimeout && imageTransfer) || pfDuringImage) begin
				imgToPend_q <= 1'b1; // RL10 RL18
			end else if (canPick && pick == `SED_H_IMAGE_TO) begin
				imgToPend_q <= 1'b0;
			end
			if (blockCallUnloaded) begin
				unldPend_q <= 1'b1;
			end else if (canPick && pick == `SED_H_UNLOADED) begin
				unldPend_q <= 1'b0;
			end
			if (substEvent) begin
				substPend_q <= 1'b1; // RL20
			end else if (canPick && pick == `SED_H_SUBST) begin
				substPend_q <= 1'b0;
			end
		end
	end

	// Fault records
	always @(posedge clock) begin
		if (!rst_n) begin
			callCode_q <= 16'h0000;
			faultAddr_q <= 32'h0000_0000;
		end else begin
			if (blockCallUnloaded) begin
				callCode_q <= callIndirect ? callWord2 : callWord1; // RL14
			end
			if (ackTimeout || pfDuringImage) begin
				faultAddr_q <= accessAddress; // RL16 RL18
			end
		end
	end

	// Dispatch sequencer
	always @(posedge clock) begin
		if (!rst_n) begin
			state_q <= ST_IDLE;
			curHandler_q <= `SED_H_NONE;
			ioServed_q <= 4'h0;
			dispatch <= 1'b0;
			handlerId <= `SED_H_NONE;
			firstAccumulator <= 16'h0000;
			handlerActive <= 1'b0;
			resumeNext <= 1'b0;
			stopMode <= 1'b0;
			refuseStart <= 1'b0;
			diagCode <= `SED_DIAG_NONE;
		end else begin
			dispatch <= 1'b0;
			resumeNext <= 1'b0;
			if (restartPhase && |ioRise) begin
				refuseStart <= 1'b1; // RL7
				stopMode <= 1'b1;
				diagCode <= `SED_DIAG_RESTART_IO;
			end else if (take) begin
				state_q <= ST_BUSY; // RL1 RL5 RL13 RL19
				curHandler_q <= pick;
				ioServed_q <= ioClr;
				dispatch <= 1'b1;
				handlerId <= pick;
				firstAccumulator <= pickCode; // RL1 RL5
				handlerActive <= 1'b1;
			end else if (canPick) begin
				case (pick)
					`SED_H_COLLISION: ; // RL2
					`SED_H_UNLOADED: resumeNext <= 1'b1; // RL15
					`SED_H_IO_ERROR: begin
						stopMode <= 1'b1; // RL6
						diagCode <= `SED_DIAG_IO_ERROR;
					end
					`SED_H_SUBST: begin
						stopMode <= 1'b1; // RL19
						diagCode <= `SED_DIAG_SUBST;
					end
					default: begin
						stopMode <= 1'b1; // RL13 RL17 RL18
						diagCode <= `SED_DIAG_ACK_TO;
					end
				endcase
			end else if (state_q == ST_BUSY && handlerDone) begin
				state_q <= ST_IDLE;
				curHandler_q <= `SED_H_NONE;
				handlerActive <= 1'b0;
			end
		end
	end

	// Status layout; bit 4 is spare and reads zero
	wire [31:0] statusWord = {
		8'h00,
		refuseStart,
		stopMode,
		diagCode,
		ioPend_q,
		collPend_q,
		dirToPend_q,
		imgToPend_q,
		unldPend_q,
		substPend_q,
		1'b0,
		handlerActive,
		handlerId
	};

	// AHB-Lite register slave, zero wait states
	always @(posedge clock) begin
		if (!rst_n) begin
			wrPend_q <= 1'b0;
			addrIdx_q <= 20'h0_0000;
			hrdata <= 32'h0000_0000;
			handlers_q <= `SED_HANDLERS_RST;
			levelMask_q <= `SED_MASK_RST;
		end else begin
			wrPend_q <= addrPhase && hwrite;
			if (addrPhase) begin
				addrIdx_q <= haddr[21:2];
			end
			// Writes land at the data phase edge, when hwdata stands
			if (wrPend_q && addrIdx_q == `SED_IDX_HANDLERS) begin
				handlers_q <= hwdata[5:0];
			end
			if (wrPend_q && addrIdx_q == `SED_IDX_LEVEL_MASK) begin
				levelMask_q <= hwdata[5:0];
			end
			// Launched at the address edge so it stands through the data phase
			hrdata <= 32'h0000_0000;
			if (addrPhase && !hwrite) begin
				if (isIdx(haddr, `SED_IDX_CALL_CODE)) begin
					hrdata <= {16'h0000, callCode_q};
				end else if (isIdx(haddr, `SED_IDX_FAULT_ADDR)) begin
					hrdata <= faultAddr_q;
				end else if (isIdx(haddr, `SED_IDX_HANDLERS)) begin
					hrdata <= {26'h000_0000, handlers_q};
				end else if (isIdx(haddr, `SED_IDX_LEVEL_MASK)) begin
					hrdata <= {26'h000_0000, levelMask_q};
				end else if (isIdx(haddr, `SED_IDX_STATUS)) begin
					hrdata <= statusWord;
				end
			end
		end
	end
endmodule

// >>> bench/sed_dispatcher_asserts.sv
// Concurrent checks on the dispatcher ports
`timescale 1ns/1ps
module sed_dispatcher_asserts #(
	parameter ACK_CYCLES = 16000
) (
	// Clock and reset
	input wire clock,
	input wire rst_n,
	// Dispatch side
	input wire handlerDone,
	input wire dispatch,
	input wire [2:0] handlerId,
	input wire [15:0] firstAccumulator,
	input wire handlerActive,
	input wire resumeNext,
	input wire stopMode,
	input wire refuseStart,
	input wire [3:0] diagCode,
	input wire scanMonitorRun
);
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_n);
	a_coll_code: assert property (dispatch && handlerId == 3'h0 |-> firstAccumulator inside {[1:5]})
		else $error("collision code out of range");
	a_io_code: assert property (dispatch && handlerId == 3'h1 |-> firstAccumulator inside {[1:4]})
		else $error("io code out of range");
	a_dispatch_active: assert property (dispatch |-> handlerActive)
		else $error("dispatch without active handler");
	a_busy_hold: assert property (handlerActive && !handlerDone |=> !dispatch)
		else $error("dispatch while handler busy");
	a_stop_sticky: assert property (stopMode |=> stopMode)
		else $error("stop mode left without reset");
	a_stop_quiet: assert property (stopMode |=> !dispatch)
		else $error("dispatch in stop mode");
	a_stop_diag: assert property ($rose(stopMode) |-> diagCode != 4'h0)
		else $error("stop without diagnostic");
	a_refuse_stop: assert property (refuseStart |-> stopMode && diagCode == 4'h4)
		else $error("refused start not stopped");
	a_scan_run: assert property (scanMonitorRun == !stopMode)
		else $error("scan monitor state wrong");
	c_io_dispatch: cover property (dispatch && handlerId == 3'h1);
	c_resume: cover property (resumeNext);
	c_refuse: cover property ($rose(refuseStart));
endmodule

// >>> bench/sed_backplane_model.sv
// Backplane modules answering the dispatcher's accesses
`timescale 1ns/1ps
module sed_backplane_model (
	// Clock
	input wire clock,
	// Access state and scenario controls
	input wire directAccess,
	input wire imageTransfer,
	input wire [7:0] ackDelay,
	input wire [3:0] errorLevel,
	// Backplane pins
	output logic moduleAckPin,
	output wire [3:0] ioErrorPin
);
	logic [7:0] waitCount_q;
	assign ioErrorPin = errorLevel;
	// Zero delay models a module that never answers
	always @(posedge clock) begin
		if (!(directAccess || imageTransfer)) begin
			waitCount_q <= 8'h00;
			moduleAckPin <= 1'b0;
		end else begin
			waitCount_q <= waitCount_q + 8'h01;
			moduleAckPin <= ackDelay != 8'h00 && waitCount_q >= ackDelay;
		end
	end
endmodule

// >>> bench/sed_dispatcher_test.sv
// Self-checking bench for the system error dispatcher
`timescale 1ns/1ps
`include "sed_regs.vh"
module sed_dispatcher_test;
	localparam int ACK = 20;
	logic clock, rst_n, hsel, hwrite, directAccess, imageTransfer, restartPhase, handlerDone;
	logic globalIntDisable, blockCallUnloaded, callIndirect, paramAltered, dataWordOp;
	logic [1:0] htrans;
	logic [31:0] haddr, hwdata, accessAddress, seed;
	logic [4:0] levelRequest, levelBusy;
	logic [15:0] callWord1, callWord2, dataWordIndex, dataBlockLength;
	logic [7:0] ackDelay;
	logic [3:0] errorLevel;
	wire [31:0] hrdata;
	wire hreadyout, hresp, moduleAckPin, dispatch, handlerActive, resumeNext, stopMode;
	wire refuseStart, scanMonitorRun;
	wire [3:0] ioErrorPin, diagCode;
	wire [2:0] handlerId;
	wire [15:0] firstAccumulator;
	int numErrors, numChecks, resCnt;
	logic [18:0] gotQ[$];
	sed_dispatcher #(.ACK_CYCLES(ACK)) i_sed_dispatcher (
		.clock, .rst_n, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
		.hready(hreadyout), .hrdata, .hreadyout, .hresp, .levelRequest, .levelBusy,
		.ioErrorPin, .moduleAckPin, .directAccess, .imageTransfer, .accessAddress,
		.restartPhase, .globalIntDisable, .handlerDone, .blockCallUnloaded, .callIndirect,
		.callWord1, .callWord2, .paramAltered, .dataWordOp, .dataWordIndex, .dataBlockLength,
		.dispatch, .handlerId, .firstAccumulator, .handlerActive, .resumeNext, .stopMode,
		.refuseStart, .diagCode, .scanMonitorRun
	);
	sed_backplane_model i_sed_backplane_model (
		.clock, .directAccess, .imageTransfer, .ackDelay, .errorLevel, .moduleAckPin, .ioErrorPin
	);
	initial begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end
	// Every dispatch is queued so none slips past a busy task
	always @(posedge clock) begin
		if (dispatch === 1'b1) gotQ.push_back({handlerId, firstAccumulator});
		if (resumeNext === 1'b1) resCnt++;
	end
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	task automatic testDone();
		$display("checks %0d errors %0d", numChecks, numErrors);
		if (numErrors == 0 && numChecks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	task automatic chk(input bit ok, input string m);
		numChecks++;
		if (!ok) begin
			$display("mismatch %0t %s", $time, m);
			numErrors++;
		end
	endtask
	task automatic rst();
		@(posedge clock);
		rst_n <= 1'b0;
		errorLevel <= 4'h0;
		repeat (5) @(posedge clock);
		rst_n <= 1'b1;
		gotQ.delete();
	endtask
	task automatic bus(input bit w, input logic [31:0] a, d, output logic [31:0] r);
		@(posedge clock);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= a;
		hwrite <= w;
		do @(posedge clock); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hsel <= 1'b0;
		hwdata <= d;
		do @(posedge clock); while (hreadyout !== 1'b1);
		r = hrdata;
	endtask
	task automatic wr(input logic [31:0] a, d);
		logic [31:0] r;
		bus(1'b1, a, d, r);
	endtask
	task automatic rdChk(input logic [31:0] a, e);
		logic [31:0] r;
		bus(1'b0, a, 32'h0, r);
		chk(r === e, "read");
		chk(hresp === 1'b0, "error response");
	endtask
	task automatic serve(input logic [2:0] id, input logic [15:0] acc);
		int n;
		logic [18:0] g;
		n = 0;
		while (gotQ.size() == 0 && n < 100) begin
			@(posedge clock);
			n++;
		end
		g = gotQ.size() ? gotQ.pop_front() : 19'h7_FFFF;
		chk(g === {id, acc}, "dispatch");
		@(posedge clock);
		handlerDone <= 1'b1;
		@(posedge clock);
		handlerDone <= 1'b0;
	endtask
	task automatic none(input int n);
		repeat (n) @(posedge clock);
		chk(gotQ.size() == 0, "extra dispatch");
	endtask
	task automatic coll(input int k, input bit b);
		@(posedge clock);
		levelRequest <= 5'h01 << k;
		levelBusy <= b ? 5'h01 << k : 5'h00;
		@(posedge clock);
		levelRequest <= 5'h00;
	endtask
	task automatic hit(input int s);
		@(posedge clock);
		{paramAltered, dataWordOp, blockCallUnloaded} <= 3'(1 << s);
		@(posedge clock);
		{paramAltered, dataWordOp, blockCallUnloaded} <= 3'h0;
	endtask
	task automatic unl(input bit ind, output logic [15:0] e);
		logic [31:0] v;
		v = rnd();
		callIndirect <= ind;
		{callWord1, callWord2} <= v;
		e = ind ? v[15:0] : v[31:16];
		hit(0);
	endtask
	initial begin
		#500000;
		numErrors++;
		testDone();
	end
	initial begin
		logic [31:0] r;
		logic [15:0] e;
		{hsel, hwrite, htrans, haddr, hwdata, directAccess, imageTransfer, restartPhase} = 0;
		{globalIntDisable, handlerDone, blockCallUnloaded, callIndirect, paramAltered} = 0;
		{dataWordOp, levelRequest, levelBusy, callWord1, callWord2, accessAddress} = 0;
		{dataWordIndex, dataBlockLength, errorLevel} = 0;
		rst_n = 1'b0;
		ackDelay = 8'h03;
		seed = 32'h0000_3750;
		rst();
		rdChk(4 * `SED_IDX_HANDLERS, 32'h0000_0000);
		rdChk(32'h0000_0100, 32'h0000_0000);
		wr(4 * `SED_IDX_CALL_CODE, 32'h0000_5A5A);
		bus(1'b0, 4 * `SED_IDX_CALL_CODE, 32'h0, r);
		chk(r[15:0] !== 16'h5A5A, "read-only written");
		wr(4 * `SED_IDX_HANDLERS, 32'h0000_003F);
		rdChk(4 * `SED_IDX_HANDLERS, 32'h0000_003F);
		$display("registers done");
		for (int k = 0; k < 5; k++) begin
			coll(k, 1'b1);
			serve(3'h0, 16'(k + 1));
		end
		coll(2, 1'b0);
		none(8);
		globalIntDisable <= 1'b1;
		coll(0, 1'b1);
		repeat (4) @(posedge clock);
		coll(0, 1'b1);
		coll(0, 1'b1);
		serve(3'h0, 16'h0001);
		serve(3'h0, 16'h0001);
		none(8);
		$display("collisions done");
		for (int k = 0; k < 4; k++) begin
			errorLevel <= 4'h1 << k;
			serve(3'h1, 16'(k + 1));
			errorLevel <= 4'h0;
			repeat (4) @(posedge clock);
			serve(3'h1, 16'(k + 1));
			none(8);
		end
		accessAddress <= rnd();
		imageTransfer <= 1'b1;
		errorLevel <= 4'h1;
		repeat (6) @(posedge clock);
		errorLevel <= 4'h0;
		imageTransfer <= 1'b0;
		repeat (4) @(posedge clock);
		serve(3'h1, 16'h0001);
		serve(3'h4, 16'h0000);
		rdChk(4 * `SED_IDX_FAULT_ADDR, accessAddress);
		ackDelay <= 8'h00;
		directAccess <= 1'b1;
		accessAddress <= rnd();
		serve(3'h3, 16'h0000);
		directAccess <= 1'b0;
		rdChk(4 * `SED_IDX_FAULT_ADDR, accessAddress);
		ackDelay <= 8'h03;
		directAccess <= 1'b1;
		repeat (40) @(posedge clock);
		directAccess <= 1'b0;
		none(4);
		$display("io and timeouts done");
		for (int i = 0; i < 2; i++) begin
			unl(i[0], e);
			serve(3'h2, 16'h0000);
			rdChk(4 * `SED_IDX_CALL_CODE, {16'h0000, e});
		end
		dataBlockLength <= 16'h0010;
		dataWordIndex <= 16'h0010;
		hit(1);
		none(8);
		dataWordIndex <= 16'h0011;
		hit(1);
		serve(3'h5, 16'h0000);
		hit(2);
		serve(3'h5, 16'h0000);
		$display("programming errors done");
		wr(4 * `SED_IDX_HANDLERS, 32'h0000_0000);
		coll(1, 1'b1);
		none(8);
		unl(1'b0, e);
		none(8);
		chk(resCnt == 1, "no resume");
		errorLevel <= 4'h2;
		repeat (8) @(posedge clock);
		chk(stopMode === 1'b1 && diagCode === `SED_DIAG_IO_ERROR, "no stop");
		rst();
		wr(4 * `SED_IDX_HANDLERS, 32'h0000_003F);
		restartPhase <= 1'b1;
		errorLevel <= 4'h8;
		repeat (8) @(posedge clock);
		chk(refuseStart === 1'b1 && diagCode === `SED_DIAG_RESTART_IO, "started");
		restartPhase <= 1'b0;
		rst();
		hit(1);
		repeat (4) @(posedge clock);
		chk(stopMode === 1'b1 && diagCode === `SED_DIAG_SUBST, "no subst stop");
		rst();
		ackDelay <= 8'h00;
		directAccess <= 1'b1;
		repeat (40) @(posedge clock);
		chk(stopMode === 1'b1 && diagCode === `SED_DIAG_ACK_TO, "no timeout stop");
		directAccess <= 1'b0;
		$display("stop cases done");
		testDone();
	end
endmodule
bind sed_dispatcher sed_dispatcher_asserts #(.ACK_CYCLES(ACK_CYCLES)) i_sed_dispatcher_asserts (
	.clock, .rst_n, .handlerDone, .dispatch, .handlerId, .firstAccumulator, .handlerActive,
	.resumeNext, .stopMode, .refuseStart, .diagCode, .scanMonitorRun
);
